// File: logic/tpc_pkg.sv
// Shared constants for the phase correction and result output block.
// Assumes a byte-wide register address behind the serial front end.
package tpc_pkg;
  localparam int RW = 24;
  // Register addresses
  localparam logic [7:0] A_PH = 8'h08;
  localparam logic [7:0] A_AMP = 8'h09;
  localparam logic [7:0] A_AT = 8'h0a;
  localparam logic [7:0] A_FC = 8'h0f;
  localparam logic [7:0] A_CNT = 8'h10;
  localparam logic [7:0] A_L0 = 8'h4a;
  localparam logic [7:0] A_L1 = 8'h4b;
  localparam logic [7:0] A_L2 = 8'h4c;
  localparam logic [7:0] A_L3 = 8'h4d;
  localparam logic [7:0] A_L4 = 8'h4e;
  localparam logic [7:0] A_H0 = 8'ha2;
  localparam logic [7:0] A_H1 = 8'ha7;
  localparam logic [7:0] A_H4A = 8'haa;
  localparam logic [7:0] A_H4B = 8'hab;
  localparam logic [7:0] A_H2 = 8'hac;
  localparam logic [7:0] A_H3 = 8'hb1;
  // Reset values and limits
  localparam logic [3:0] DIV_RST = 4'ha;
  localparam logic [14:0] CNT_MAX = 15'h7fff;
  // Calibration control field positions
  localparam int F_START = 16;
  localparam int F_DIV = 17;
  localparam int F_USE = 21;
  localparam int F_FLP = 22;
  localparam int F_FCR = 23;
  localparam int F_CONT = 15;
  // Nonlinearity control field positions
  localparam int N_EN = 0;
  localparam int N_A0 = 2;
  localparam int N_SC = 18;
  localparam int H_BYTE = 16;
  // Result word field positions
  localparam int O_PH = 0;
  localparam int O_OVF = 16;
  localparam int O_HDR = 17;
  localparam int O_TX = 18;
  localparam int O_VAL = 20;
  localparam int O_MF = 21;
  localparam int O_AOV = 22;
  localparam int O_FC0 = 23;
  localparam int O_AMP = 0;
  localparam int O_FC1 = 16;
  localparam int O_SOV = 18;
  localparam int O_OV2 = 19;
  localparam int O_BIN = 20;
  localparam int O_FC2 = 0;
  localparam int O_AMB = 2;
  localparam int O_TMP = 12;
  // Arithmetic shifts of the correction datapath
  localparam int FC_SHIFT = 15;
  localparam int NL_SHIFT = 16;
endpackage

// File: logic/tpc_fcal_if.sv
// Control and result signals between the register side and the
// frequency calibration counter; both ends share one clock.
`timescale 1ns/1ps
interface tpc_fcal_if;
  logic enable;
  logic continuous;
  logic start;
  logic [3:0] divider;
  logic [14:0] count;
  logic done;
  logic busy;
  modport ctl (output enable, continuous, start, divider,
               input count, done, busy);
  modport cal (input enable, continuous, start, divider,
               output count, done, busy);
endinterface

// File: logic/tpc_fcal.sv
// Frequency calibration counter: counts divided system clock ticks
// between two rising edges of the reference input.
// Assumes the reference is already synchronous to clk_i.
`timescale 1ns/1ps
module tpc_fcal (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ref_clk_i,
  tpc_fcal_if.cal fc
);
  typedef enum logic [1:0] {C_IDLE, C_ARM, C_COUNT} tpc_cst_t;
  typedef struct packed {
    tpc_cst_t st;
    logic [15:0] dcnt;
    logic [14:0] ticks;
    logic ref_d;
    logic [14:0] count;
    logic done;
    logic busy;
  } tpc_fcal_st_t;

  tpc_fcal_st_t s_r;
  tpc_fcal_st_t s_nxt;
  logic [15:0] dlim;
  logic tick;
  logic ref_rise;

  // Divide by two to the divider
  assign dlim = 16'((17'h1 << fc.divider) - 17'h1);
  assign tick = (s_r.dcnt == dlim);
  assign ref_rise = ref_clk_i & ~s_r.ref_d;

  // Results straight from the state register
  assign fc.count = s_r.count;
  assign fc.done = s_r.done;
  assign fc.busy = s_r.busy;

  // Next state of the measurement
  always_comb begin
    s_nxt = s_r;
    s_nxt.ref_d = ref_clk_i;
    s_nxt.done = 1'h0;
    if (!fc.enable) begin
      s_nxt.st = C_IDLE;
      s_nxt.busy = 1'h0;
      s_nxt.dcnt = 16'h0;
    end else begin
      case (s_r.st)
        C_IDLE: begin
          if (fc.start || fc.continuous) begin
            s_nxt.st = C_ARM;
            s_nxt.busy = 1'h1;
          end
        end
        // Wait for a reference edge to open the interval
        C_ARM: begin
          if (ref_rise) begin
            s_nxt.st = C_COUNT;
            s_nxt.dcnt = 16'h0;
            s_nxt.ticks = 15'h0;
          end
        end
        C_COUNT: begin
          s_nxt.dcnt = tick ? 16'h0 : s_r.dcnt + 16'h1;
          // Saturate rather than wrap on a missing reference
          if (tick && s_r.ticks != tpc_pkg::CNT_MAX) begin
            s_nxt.ticks = s_r.ticks + 15'h1;
          end
          if (ref_rise) begin
            s_nxt.count = s_r.ticks;
            s_nxt.done = 1'h1;
            s_nxt.dcnt = 16'h0;
            s_nxt.ticks = 15'h0;
            if (!fc.continuous) begin
              s_nxt.st = C_IDLE;
              s_nxt.busy = 1'h0;
            end
          end
        end
        default: begin
          s_nxt.st = C_IDLE;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  property p_fcal_off;
    @(posedge clk_i) disable iff (rst_i)
    !fc.enable |=> !fc.busy && !fc.done;
  endproperty
  a_fcal_off: assert property (p_fcal_off)
    else $error("calibration active while disabled");

  property p_fcal_single;
    @(posedge clk_i) disable iff (rst_i)
    fc.done && !$past(fc.continuous) |-> !fc.busy;
  endproperty
  a_fcal_single: assert property (p_fcal_single)
    else $error("single measurement did not stop");

  property p_fcal_div;
    @(posedge clk_i) disable iff (rst_i)
    s_r.st == C_COUNT && tick && $stable(fc.divider)
      |=> s_r.dcnt == 16'h0;
  endproperty
  a_fcal_div: assert property (p_fcal_div)
    else $error("divider did not wrap at terminal count");
endmodule

// File: logic/tpc_top.sv
// Result output stage of the depth sensor: frequency calibration,
// frequency and nonlinearity correction of the phase, result packing.
// Assumes a serial front end that turns host transfers into single
// cycle register reads and writes, and a depth engine that pulses
// FRAME_DONE_I with all raw results valid in that cycle.
//
// Function
// - Correction uses trimmed count when select is 0, measured when 1.
// - Calibration logic only runs while its enable bit is set.
// - Frequency correction applied to phase when its enable is set.
// - Calibration clock is system clock over two to the divider.
// - Measure on start write, or continuously when continuous bit set.
// - Latest calibration count is readable as a 15-bit field.
// - Nonlinearity correction applied only while its enable is set, and only to TX0 frames.
// - All nonlinearity coefficients are scaled by a 2-bit factor.
// - Low-current coefficient set of orders zero to four is held.
// - High-current set held, fourth order split over two upper bytes.
// - Data ready shown on a pin; host then reads the results.
// - Final calibrated phase reported as a 16-bit value.
// - Overflow flags for base and second modulation frequency.
// - Amplitude reported with signal and ambient saturation flags.
// - Drive current level and transmitter channel are reported.
// - Frames marked valid, invalid during crosstalk measurement.
// - Modulation frequency of the frame reported as one bit.
// - Five-bit frame counter spread across the three result words.
// - Distance bin reported in a 4-bit field.
// - Ambient level reported as a 10-bit field.
// - Temperature reported as a 12-bit code.
`timescale 1ns/1ps
module tpc_top (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [23:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  output logic [23:0] REG_RDATA_O,
  output logic REG_RVALID_O,
  input wire logic REF_CLK_I,
  input wire logic [14:0] TRIM_COUNT_I,
  input wire logic FRAME_DONE_I,
  input wire logic [15:0] RAW_PHASE_I,
  input wire logic [15:0] AMPLITUDE_I,
  input wire logic SIG_SAT_I,
  input wire logic AMB_SAT_I,
  input wire logic DRIVE_HIGH_I,
  input wire logic [1:0] TX_CHANNEL_I,
  input wire logic FRAME_VALID_I,
  input wire logic XTALK_BUSY_I,
  input wire logic MODULATION_FREQ_USED_I,
  input wire logic [3:0] RANGE_BIN_I,
  input wire logic [9:0] AMBIENT_I,
  input wire logic [11:0] TEMP_CODE_I,
  output logic DATA_READY_O
);
  typedef enum logic [2:0] {P_IDLE, P_FREQ, P_NL, P_APPLY, P_PUB}
    tpc_pst_t;
  typedef struct packed {
    logic use_meas;
    logic floop;
    logic fcorr;
    logic [3:0] div;
    logic [14:0] lim;
    logic start;
    logic cont;
    logic nl_en;
    logic [1:0] scale;
    logic [4:0][15:0] clo;
    logic [4:0][15:0] chi;
    logic [23:0] w8;
    logic [23:0] w9;
    logic [23:0] w10;
    logic [23:0] s8;
    logic [23:0] s9;
    logic [23:0] s10;
    logic [4:0] fcnt;
    tpc_pst_t pst;
    logic [15:0] ph;
    logic signed [31:0] acc;
    logic [1:0] iter;
    logic hsel;
    logic tx0;
    logic [23:0] rdata;
    logic rvalid;
    logic drdy;
    logic pub;
  } tpc_top_st_t;

  tpc_top_st_t s_r;
  tpc_top_st_t s_nxt;
  tpc_fcal_if fcif ();
  logic [14:0] sel_cnt;
  logic signed [15:0] ferr;
  logic signed [32:0] fprod;
  logic signed [17:0] fsum;
  logic fovf;
  logic [15:0] coef;
  logic signed [48:0] nprod;
  logic signed [31:0] corr;
  logic [4:0] fnew;
  logic wr_hit;
  logic rd_ph;

  // Calibration counter shares this module's control fields
  assign fcif.enable = s_r.floop;
  assign fcif.continuous = s_r.cont;
  assign fcif.start = s_r.start;
  assign fcif.divider = s_r.div;

  tpc_fcal u_fcal (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .ref_clk_i(REF_CLK_I),
    .fc(fcif.cal)
  );

  assign sel_cnt = s_r.use_meas ? fcif.count : TRIM_COUNT_I;
  assign ferr = $signed({1'h0, sel_cnt}) - $signed({1'h0, s_r.lim});
  // Shift stands in for a divide by the limit; it keeps one multiplier
  assign fprod = $signed({1'h0, s_r.ph}) * ferr;
  assign fsum = $signed({2'h0, s_r.ph})
              + $signed(fprod[32:tpc_pkg::FC_SHIFT]);
  assign fovf = fsum[17] | fsum[16];

  // Coefficient set follows the frame's drive level
  always_comb begin
    coef = s_r.hsel ? s_r.chi[s_r.iter] : s_r.clo[s_r.iter];
  end

  // One Horner step per cycle: acc times phase plus next coefficient
  assign nprod = s_r.acc * $signed({1'h0, s_r.ph});
  // Scale applies to the summed polynomial
  assign corr = s_r.acc <<< s_r.scale;
  assign fnew = s_r.fcnt + 5'h1;
  assign wr_hit = REG_WR_I;
  assign rd_ph = REG_RD_I && REG_ADDR_I == tpc_pkg::A_PH;

  always_comb begin
    s_nxt = s_r;
    s_nxt.start = 1'h0;
    s_nxt.pub = 1'h0;
    s_nxt.rvalid = REG_RD_I;
    // Register writes; result words are read only
    if (wr_hit) begin
      case (REG_ADDR_I)
        tpc_pkg::A_FC: begin
          s_nxt.lim = REG_WDATA_I[14:0];
          // Start bit is a self-clearing trigger
          s_nxt.start = REG_WDATA_I[tpc_pkg::F_START];
          s_nxt.div = REG_WDATA_I[tpc_pkg::F_DIV +: 4];
          s_nxt.use_meas = REG_WDATA_I[tpc_pkg::F_USE];
          s_nxt.floop = REG_WDATA_I[tpc_pkg::F_FLP];
          s_nxt.fcorr = REG_WDATA_I[tpc_pkg::F_FCR];
        end
        tpc_pkg::A_CNT: begin
          s_nxt.cont = REG_WDATA_I[tpc_pkg::F_CONT];
        end
        // Control and order zero share one register
        tpc_pkg::A_L0: begin
          s_nxt.nl_en = REG_WDATA_I[tpc_pkg::N_EN];
          s_nxt.clo[0] = REG_WDATA_I[tpc_pkg::N_A0 +: 16];
          s_nxt.scale = REG_WDATA_I[tpc_pkg::N_SC +: 2];
        end
        tpc_pkg::A_L1: s_nxt.clo[1] = REG_WDATA_I[15:0];
        tpc_pkg::A_L2: s_nxt.clo[2] = REG_WDATA_I[15:0];
        tpc_pkg::A_L3: s_nxt.clo[3] = REG_WDATA_I[15:0];
        tpc_pkg::A_L4: s_nxt.clo[4] = REG_WDATA_I[15:0];
        tpc_pkg::A_H0: s_nxt.chi[0] = REG_WDATA_I[15:0];
        tpc_pkg::A_H1: s_nxt.chi[1] = REG_WDATA_I[15:0];
        tpc_pkg::A_H2: s_nxt.chi[2] = REG_WDATA_I[15:0];
        tpc_pkg::A_H3: s_nxt.chi[3] = REG_WDATA_I[15:0];
        // Fourth order split across two upper bytes
        tpc_pkg::A_H4A: begin
          s_nxt.chi[4][15:8] = REG_WDATA_I[tpc_pkg::H_BYTE +: 8];
        end
        tpc_pkg::A_H4B: begin
          s_nxt.chi[4][7:0] = REG_WDATA_I[tpc_pkg::H_BYTE +: 8];
        end
        default: begin
        end
      endcase
    end
    // Register reads, one cycle latency; unmapped reads give zero
    s_nxt.rdata = 24'h0;
    if (REG_RD_I) begin
      case (REG_ADDR_I)
        tpc_pkg::A_PH: s_nxt.rdata = s_r.w8;
        tpc_pkg::A_AMP: s_nxt.rdata = s_r.w9;
        tpc_pkg::A_AT: s_nxt.rdata = s_r.w10;
        tpc_pkg::A_FC: begin
          s_nxt.rdata = {s_r.fcorr, s_r.floop, s_r.use_meas, s_r.div,
                         2'h0, s_r.lim};
        end
        tpc_pkg::A_CNT: s_nxt.rdata = {8'h0, s_r.cont, fcif.count};
        tpc_pkg::A_L0: begin
          s_nxt.rdata = {4'h0, s_r.scale, s_r.clo[0], 1'h0, s_r.nl_en};
        end
        tpc_pkg::A_L1: s_nxt.rdata = {8'h0, s_r.clo[1]};
        tpc_pkg::A_L2: s_nxt.rdata = {8'h0, s_r.clo[2]};
        tpc_pkg::A_L3: s_nxt.rdata = {8'h0, s_r.clo[3]};
        tpc_pkg::A_L4: s_nxt.rdata = {8'h0, s_r.clo[4]};
        tpc_pkg::A_H0: s_nxt.rdata = {8'h0, s_r.chi[0]};
        tpc_pkg::A_H1: s_nxt.rdata = {8'h0, s_r.chi[1]};
        tpc_pkg::A_H2: s_nxt.rdata = {8'h0, s_r.chi[2]};
        tpc_pkg::A_H3: s_nxt.rdata = {8'h0, s_r.chi[3]};
        tpc_pkg::A_H4A: s_nxt.rdata = {s_r.chi[4][15:8], 16'h0};
        tpc_pkg::A_H4B: s_nxt.rdata = {s_r.chi[4][7:0], 16'h0};
        default: s_nxt.rdata = 24'h0;
      endcase
    end
    // Reading the phase word clears the ready level
    if (rd_ph) begin
      s_nxt.drdy = 1'h0;
    end
    // Correction pipeline; a frame arriving while busy is dropped
    case (s_r.pst)
      P_IDLE: begin
        if (FRAME_DONE_I) begin
          s_nxt.pst = P_FREQ;
          s_nxt.ph = RAW_PHASE_I;
          s_nxt.hsel = DRIVE_HIGH_I;
          s_nxt.tx0 = (TX_CHANNEL_I == 2'h0);
          s_nxt.s8 = 24'h0;
          s_nxt.s8[tpc_pkg::O_HDR] = DRIVE_HIGH_I;
          s_nxt.s8[tpc_pkg::O_TX +: 2] = TX_CHANNEL_I;
          s_nxt.s8[tpc_pkg::O_VAL] = FRAME_VALID_I & ~XTALK_BUSY_I;
          s_nxt.s8[tpc_pkg::O_MF] = MODULATION_FREQ_USED_I;
          s_nxt.s8[tpc_pkg::O_AOV] = AMB_SAT_I;
          s_nxt.s9 = 24'h0;
          s_nxt.s9[tpc_pkg::O_AMP +: 16] = AMPLITUDE_I;
          s_nxt.s9[tpc_pkg::O_SOV] = SIG_SAT_I;
          s_nxt.s9[tpc_pkg::O_BIN +: 4] = RANGE_BIN_I;
          s_nxt.s10 = 24'h0;
          s_nxt.s10[tpc_pkg::O_AMB +: 10] = AMBIENT_I;
          s_nxt.s10[tpc_pkg::O_TMP +: 12] = TEMP_CODE_I;
        end
      end
      P_FREQ: begin
        if (s_r.fcorr) begin
          s_nxt.ph = fsum[15:0];
          if (s_r.s8[tpc_pkg::O_MF]) begin
            s_nxt.s9[tpc_pkg::O_OV2] = fovf;
          end else begin
            s_nxt.s8[tpc_pkg::O_OVF] = fovf;
          end
        end
        // Nonlinearity only when enabled, and only on TX0 frames
        if (s_r.nl_en && s_r.tx0) begin
          s_nxt.pst = P_NL;
          s_nxt.iter = 2'h3;
          s_nxt.acc = 32'($signed(s_r.hsel ? s_r.chi[4] : s_r.clo[4]));
        end else begin
          s_nxt.pst = P_PUB;
        end
      end
      P_NL: begin
        s_nxt.acc = nprod[tpc_pkg::NL_SHIFT +: 32] + 32'($signed(coef));
        s_nxt.iter = s_r.iter - 2'h1;
        if (s_r.iter == 2'h0) begin
          s_nxt.pst = P_APPLY;
        end
      end
      P_APPLY: begin
        // Phase wraps modulo full scale, as a phase should
        s_nxt.ph = s_r.ph + corr[15:0];
        s_nxt.pst = P_PUB;
      end
      P_PUB: begin
        // All three words change in one cycle
        s_nxt.w8 = s_r.s8;
        s_nxt.w8[tpc_pkg::O_PH +: 16] = s_r.ph;
        s_nxt.w8[tpc_pkg::O_FC0] = fnew[0];
        s_nxt.w9 = s_r.s9;
        s_nxt.w9[tpc_pkg::O_FC1 +: 2] = fnew[2:1];
        s_nxt.w10 = s_r.s10;
        s_nxt.w10[tpc_pkg::O_FC2 +: 2] = fnew[4:3];
        s_nxt.fcnt = fnew;
        // Set wins over a same-cycle clear
        s_nxt.drdy = 1'h1;
        s_nxt.pub = 1'h1;
        s_nxt.pst = P_IDLE;
      end
      default: begin
        s_nxt.pst = P_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      s_r <= '0;
      s_r.div <= tpc_pkg::DIV_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs come straight from the state register
  assign REG_RDATA_O = s_r.rdata;
  assign REG_RVALID_O = s_r.rvalid;
  assign DATA_READY_O = s_r.drdy;

  sequence s_frame_in;
    s_r.pst == P_IDLE && FRAME_DONE_I;
  endsequence
  sequence s_xtalk_in;
    s_r.pst == P_IDLE && FRAME_DONE_I && XTALK_BUSY_I;
  endsequence

  property p_publish;
    @(posedge CLK_I) disable iff (RST_I)
    s_frame_in |-> ##[3:8] s_r.pub;
  endproperty
  a_publish: assert property (p_publish)
    else $error("frame not published in time");

  property p_fcnt;
    @(posedge CLK_I) disable iff (RST_I)
    s_r.pub |-> s_r.fcnt == 5'($past(s_r.fcnt) + 5'h1)
      && s_r.w8[tpc_pkg::O_FC0] == s_r.fcnt[0]
      && s_r.w9[tpc_pkg::O_FC1 +: 2] == s_r.fcnt[2:1]
      && s_r.w10[tpc_pkg::O_FC2 +: 2] == s_r.fcnt[4:3];
  endproperty
  a_fcnt: assert property (p_fcnt)
    else $error("frame counter fields wrong");

  property p_drdy_hold;
    @(posedge CLK_I) disable iff (RST_I)
    (DATA_READY_O && !rd_ph) || s_r.pst == P_PUB |=> DATA_READY_O;
  endproperty
  a_drdy_hold: assert property (p_drdy_hold)
    else $error("data ready dropped before phase read");

  property p_nofcorr;
    @(posedge CLK_I) disable iff (RST_I)
    s_r.pst == P_FREQ && !s_r.fcorr |=> s_r.ph == $past(s_r.ph);
  endproperty
  a_nofcorr: assert property (p_nofcorr)
    else $error("phase changed with correction disabled");

  property p_nonl;
    @(posedge CLK_I) disable iff (RST_I)
    s_r.pst == P_FREQ && !s_r.nl_en |=> s_r.pst == P_PUB;
  endproperty
  a_nonl: assert property (p_nonl)
    else $error("nonlinearity step ran while disabled");

  property p_xtalk;
    @(posedge CLK_I) disable iff (RST_I)
    s_xtalk_in |-> ##[3:8] (s_r.pub && !s_r.w8[tpc_pkg::O_VAL]);
  endproperty
  a_xtalk: assert property (p_xtalk)
    else $error("crosstalk frame marked valid");
endmodule

// File: testbench/tpc_host.sv
// Host model: drives the register strobe port of the result block.
// Assumes one shared clock; the bench calls its tasks by path.
`timescale 1ns/1ps
module tpc_host (
  input wire logic clk_i,
  output logic [7:0] addr_o,
  output logic [23:0] wdata_o,
  output logic wr_o,
  output logic rd_o
);
  // Expected read results, mask in the upper half
  logic [47:0] exp_q[$];

  initial begin
    addr_o = 8'h00;
    wdata_o = 24'h000000;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end

  task automatic wr(input logic [7:0] a, input logic [23:0] d);
    @(posedge clk_i);
    #1 addr_o = a;
    wdata_o = d;
    wr_o = 1'b1;
    @(posedge clk_i);
    #1 wr_o = 1'b0;
    wdata_o = ~d; // Stale data must never be taken
  endtask

  task automatic rd(input logic [7:0] a, input logic [23:0] e,
                    input logic [23:0] m);
    @(posedge clk_i);
    #1 addr_o = a;
    rd_o = 1'b1;
    exp_q.push_back({m, e});
    @(posedge clk_i);
    #1 rd_o = 1'b0;
  endtask
endmodule

// File: testbench/tb_tpc_top.sv
// Self-checking bench for the result output block.
// Assumes the host model file is compiled before this one.
`timescale 1ns/1ps
module tb_tpc_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr;
  logic [23:0] wd, rdat;
  logic wr, rd, rv, ref_clk, fd, dr;
  logic [14:0] trim;
  logic [15:0] ph, amp;
  logic ssat, asat, hdr, fv, xb, mf;
  logic [1:0] tx;
  logic [3:0] bin;
  logic [9:0] amb;
  logic [11:0] tmp;
  logic [31:0] seed;
  longint pl;
  logic [15:0] pv;
  logic [4:0] fcn = 5'h0;
  int bad_count = 0;
  int checked = 0;
  logic [7:0] ra[5] = '{8'h0f, 8'h4a, 8'h4b, 8'haa, 8'hb1};
  logic [23:0] rm[5] = '{24'hbe7fff, 24'h0ffffd, 24'h00ffff,
                         24'hff0000, 24'h00ffff};

  tpc_host host (.clk_i(clk), .addr_o(addr), .wdata_o(wd),
                 .wr_o(wr), .rd_o(rd));

  tpc_top DUT (.CLK_I(clk), .RST_I(rst), .REG_ADDR_I(addr),
    .REG_WDATA_I(wd), .REG_WR_I(wr), .REG_RD_I(rd),
    .REG_RDATA_O(rdat), .REG_RVALID_O(rv), .REF_CLK_I(ref_clk),
    .TRIM_COUNT_I(trim), .FRAME_DONE_I(fd), .RAW_PHASE_I(ph),
    .AMPLITUDE_I(amp), .SIG_SAT_I(ssat), .AMB_SAT_I(asat),
    .DRIVE_HIGH_I(hdr), .TX_CHANNEL_I(tx), .FRAME_VALID_I(fv),
    .XTALK_BUSY_I(xb), .MODULATION_FREQ_USED_I(mf), .RANGE_BIN_I(bin),
    .AMBIENT_I(amb), .TEMP_CODE_I(tmp), .DATA_READY_O(dr));

  always #4 clk = ~clk;

  // Reference of 66 clocks, free running like an external crystal
  always begin
    repeat (33) @(posedge clk);
    #1 ref_clk = ~ref_clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input string n, input logic [23:0] e,
                     input logic [23:0] g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Oldest note is compared at each returned read
  always @(negedge clk) begin
    logic [47:0] e;
    if (rv === 1'b1) begin
      e = host.exp_q.size() ? host.exp_q.pop_front() : 48'hffffff000001;
      chk("read data", e[23:0], rdat & e[47:24]);
    end
  end

  // One frame; inputs scrambled after the pulse on purpose
  // Bit 16 of pe is the expected overflow flag; nlo and nhi are the
  // phase offsets of the two coefficient sets, zero when correction is off
  task automatic frame(input logic [15:0] p, input logic [16:0] pe,
                       input logic [15:0] nlo, input logic [15:0] nhi);
    int n;
    int lat;
    logic [23:0] w8, w9, wa;
    @(posedge clk);
    #1 seed = lfsr(seed);
    {amp, ssat, asat, hdr, fv, xb, mf, bin} = seed[25:0];
    tx = (seed[27:26] == 2'b11) ? 2'b00 : seed[27:26];
    seed = lfsr(seed);
    {amb, tmp} = seed[21:0];
    ph = p;
    fd = 1'b1;
    fcn = fcn + 5'h1;
    lat = 3;
    // Nonlinearity adds four Horner steps and one apply step
    if (nlo != 16'h0 && tx == 2'b00) begin
      pe[15:0] = pe[15:0] + (hdr ? nhi : nlo);
      lat = 8;
    end
    w8 = {fcn[0], asat, mf, fv & ~xb, tx, hdr, pe[16] & ~mf, pe[15:0]};
    w9 = {bin, pe[16] & mf, ssat, fcn[2:1], amp};
    wa = {tmp, amb, fcn[4:3]};
    @(posedge clk);
    #1 fd = 1'b0;
    ph = ~ph;
    amp = ~amp;
    tmp = ~tmp;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (dr !== 1'b1 && n < 20);
    chk("ready latency", 24'(lat), 24'(n));
    host.rd(tpc_pkg::A_PH, w8, 24'hffffff);
    host.rd(tpc_pkg::A_AMP, w9, 24'hffffff);
    host.rd(tpc_pkg::A_AT, wa, 24'hffffff);
    chk("ready cleared", 24'h0, {23'h0, dr});
  endtask

  initial begin
    #(8 * 20000);
    bad_count++;
    $display("watchdog expired");
    final_report;
  end

  initial begin
    seed = 32'h00015a29;
    ref_clk = 1'b0;
    fd = 1'b0;
    trim = 15'd1000;
    {ph, amp, ssat, asat, hdr, fv, xb, mf, tx, bin} = '0;
    {amb, tmp} = '0;
    repeat (8) @(posedge clk);
    #1 rst = 1'b0;
    chk("ready after reset", 24'h0, {23'h0, dr});
    host.rd(tpc_pkg::A_FC, 24'h140000, 24'hffffff);
    host.rd(tpc_pkg::A_CNT, 24'h0, 24'hffffff);
    $display("test reset done");
    // Read-back; start and calibration enable bits kept clear here
    for (int i = 0; i < 5; i++) begin
      seed = lfsr(seed);
      host.wr(ra[i], seed[23:0] & rm[i]);
      host.rd(ra[i], seed[23:0] & rm[i], 24'hffffff);
    end
    host.wr(tpc_pkg::A_PH, 24'hffffff);
    host.rd(tpc_pkg::A_PH, 24'h0, 24'hffffff);
    host.rd(8'h20, 24'h0, 24'hffffff);
    host.wr(8'h0b, 24'h000009);
    host.wr(tpc_pkg::A_L0, 24'h0);
    $display("test registers done");
    host.wr(tpc_pkg::A_FC, 24'h140000);
    for (int i = 0; i < 3; i++) begin
      seed = lfsr(seed);
      frame(seed[15:0], {1'b0, seed[15:0]}, 16'h0, 16'h0);
    end
    $display("test plain frames done");
    // Only order zero is set, so the offset is c0 shifted by scale 2
    host.wr(tpc_pkg::A_L1, 24'h0);
    host.wr(tpc_pkg::A_H3, 24'h0);
    host.wr(tpc_pkg::A_H4A, 24'h0);
    host.wr(tpc_pkg::A_H0, 24'h000200);
    host.wr(tpc_pkg::A_L0, 24'h08048d);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      frame(seed[15:0], {1'b0, seed[15:0]}, 16'h048c, 16'h0800);
    end
    host.wr(tpc_pkg::A_L0, 24'h0);
    $display("test nonlinearity done");
    for (int k = -1; k <= 1; k += 2) begin
      seed = lfsr(seed);
      host.wr(tpc_pkg::A_FC, 24'h940000 | 24'(1000 - 100 * k));
      // Raised phase makes the upward correction overflow
      pv = seed[15:0] | ((k > 0) ? 16'hffc0 : 16'h0);
      pl = pv;
      pl = pl + ((pl * 100 * k) >>> 15);
      frame(pv, {pl > 65535, pl[15:0]}, 16'h0, 16'h0);
    end
    $display("test frequency correction done");
    host.wr(tpc_pkg::A_FC, 24'h050000);
    repeat (200) @(posedge clk);
    host.rd(tpc_pkg::A_CNT, 24'h0, 24'hffffff);
    host.wr(tpc_pkg::A_FC, 24'h450000);
    repeat (200) @(posedge clk);
    host.rd(tpc_pkg::A_CNT, 24'h10, 24'h007ffe);
    host.wr(tpc_pkg::A_CNT, 24'h008000);
    repeat (200) @(posedge clk);
    host.rd(tpc_pkg::A_CNT, 24'h8010, 24'h00fffe);
    // Measured count: 66-clock reference over 4-clock ticks gives 16
    host.wr(tpc_pkg::A_FC, 24'he40011);
    seed = lfsr(seed);
    pl = seed[15:0];
    pl = pl + ((pl * (16 - 17)) >>> 15);
    frame(seed[15:0], {1'b0, pl[15:0]}, 16'h0, 16'h0);
    $display("test calibration done");
    repeat (4) @(posedge clk);
    chk("notes left", 24'h0, 24'(host.exp_q.size()));
    final_report;
  end
endmodule
